/* watchdog_timer_core.sv */
// watchdog timer core with apb control, sleep handling and interrupts
`timescale 1ns/10ps
`include "watchdog_cfg.svh"
module watchdog_timer_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator pin and configuration
  input  wire logic        low_freq_internal_osc,
  input  wire logic [1:0]  dog_mode_config,
  // cpu and clock-system events
  input  wire logic        dog_clear_instr,
  input  wire logic        sleep_active,
  input  wire logic        idle_active,
  input  wire logic        irq_wake,
  input  wire logic        osc_fail,
  input  wire logic        osc_startup_timer,
  // results
  output logic             dog_reset,
  output logic             dog_wake,
  output logic             timeout_status_flag_n,
  output logic             powerdown_status_flag_n,
  output logic             irq
);
  dog_count_if cif ();

  logic                  osc_s1_q;
  logic                  osc_s2_q;
  logic                  osc_s3_q;
  logic                  osc_lvl_q;
  logic                  tick;
  logic                  sleep_q;
  logic                  sleep_enter;
  logic                  sleep_exit;
  logic                  run;
  logic                  soft_en_q;
  watchdog_pkg::period_t period_q;
  logic                  dog_reset_q;
  logic                  dog_wake_q;
  logic                  to_n_q;
  logic                  down_n_q;
  logic [`IRQ_W-1:0]     irq_stat_q;
  logic [`IRQ_W-1:0]     irq_mask_q;
  logic [`IRQ_W-1:0]     irq_ev;
  logic [31:0]           prdata_q;
  logic [31:0]           rd_mux;
  logic                  mapped;
  logic                  wr_acc;
  logic                  asleep_or_idle;
  logic                  wr_ctrl;
  logic                  wr_irq_stat;
  logic                  wr_irq_mask;

  // address match of an accepted write; shared by every writable register
  function automatic logic wr_hit(input logic acc, input logic [11:0] addr, input logic [11:0] want);
    return acc && (addr == want);
  endfunction : wr_hit

  // oscillator pin crossing: a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      osc_lvl_q <= 1'b0;
    end else begin
      osc_s1_q <= low_freq_internal_osc;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_s2_q == osc_s3_q) begin
        osc_lvl_q <= osc_s3_q;
      end
    end
  end

  // one tick per filtered rising edge of the oscillator
  assign tick = osc_s2_q & osc_s3_q & ~osc_lvl_q;

  // sleep edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_active;
    end
  end

  assign sleep_enter = sleep_active & ~sleep_q;
  assign sleep_exit  = ~sleep_active & sleep_q;

  // operating mode decode
  always_comb begin
    unique case (dog_mode_config)
      `MODE_ON:    run = 1'b1;
      `MODE_AWAKE: run = ~sleep_active;
      `MODE_SOFT:  run = soft_en_q;
      `MODE_OFF:   run = 1'b0;
    endcase
  end

  // counter hookup; every clearing condition folds into one strobe
  assign cif.tick   = tick;
  assign cif.run    = run;
  assign cif.period = period_q;
  assign cif.clear  = dog_clear_instr
                    | sleep_enter
                    | sleep_exit
                    | irq_wake
                    | osc_fail
                    | ~run
                    | osc_startup_timer;

  dog_counter u_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (cif.cnt)
  );

  // idle and sleep both turn a time-out into a wake
  assign asleep_or_idle = sleep_active | idle_active;

  // reset strobe, registered one cycle after an awake time-out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dog_reset_q <= 1'b0;
    end else begin
      dog_reset_q <= cif.timeout & ~asleep_or_idle;
    end
  end

  // wake strobe; blocking the reset in idle keeps the cpu state intact
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dog_wake_q <= 1'b0;
    end else begin
      dog_wake_q <= cif.timeout & asleep_or_idle;
    end
  end

  assign dog_reset = dog_reset_q;
  assign dog_wake  = dog_wake_q;

  // time-out flag, active low; a time-out wins over the clear instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      to_n_q <= 1'b1;
    end else if (cif.timeout) begin
      to_n_q <= 1'b0;
    end else if (sleep_enter || dog_clear_instr) begin
      to_n_q <= 1'b1;
    end
  end

  // power-down flag, active low; sleep entry beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      down_n_q <= 1'b1;
    end else if (sleep_enter && !cif.timeout) begin
      down_n_q <= 1'b0;
    end else if (dog_clear_instr && !cif.timeout) begin
      down_n_q <= 1'b1;
    end
  end

  assign timeout_status_flag_n   = to_n_q;
  assign powerdown_status_flag_n = down_n_q;

  // apb decode; zero wait states, unmapped access answers with an error
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      `CTRL_ADDR:     rd_mux = {26'h0000000, period_q, soft_en_q};
      `STAT_ADDR:     rd_mux = {28'h0000000, osc_startup_timer, down_n_q, to_n_q, run};
      `IRQ_STAT_ADDR: rd_mux = {30'h00000000, irq_stat_q};
      `IRQ_MASK_ADDR: rd_mux = {30'h00000000, irq_mask_q};
      `COUNT_ADDR:    rd_mux = {9'h000, cif.count};
      default:        mapped = 1'b0;
    endcase
  end

  assign wr_acc  = psel & penable & pwrite & mapped & pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // one write strobe per writable register
  assign wr_ctrl     = wr_hit(wr_acc, paddr, `CTRL_ADDR);
  assign wr_irq_stat = wr_hit(wr_acc, paddr, `IRQ_STAT_ADDR);
  assign wr_irq_mask = wr_hit(wr_acc, paddr, `IRQ_MASK_ADDR);

  // read data captured in the setup cycle so it stands through the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

  // control register; only byte lane 0 carries bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      period_q  <= `PERIOD_RESET;
      soft_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      period_q  <= pwdata[`PERIOD_MSB:`PERIOD_LSB];
      soft_en_q <= pwdata[`SOFT_EN_BIT];
    end
  end

  // interrupt events
  assign irq_ev[`IRQ_RST_BIT]  = cif.timeout & ~asleep_or_idle;
  assign irq_ev[`IRQ_WAKE_BIT] = cif.timeout & asleep_or_idle;

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
    end else if (wr_irq_stat) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[`IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask_q <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_q <= pwdata[`IRQ_W-1:0];
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // time-out routing and mode decode
  awake_reset_a: assert property (cif.timeout && !asleep_or_idle |=> dog_reset && !dog_wake)
    else $error("awake time-out gave no reset");
  sleep_wake_a: assert property (cif.timeout && sleep_active |=> dog_wake && !dog_reset ##0 !to_n_q)
    else $error("sleep time-out did not wake and flag");
  idle_wake_a: assert property (cif.timeout && idle_active |=> !dog_reset && dog_wake)
    else $error("idle time-out reset the device");
  always_on_a: assert property (dog_mode_config == `MODE_ON |-> run)
    else $error("always-on mode not running");
  sleep_off_a: assert property (dog_mode_config == `MODE_AWAKE && sleep_active |-> !run)
    else $error("awake-only mode running in sleep");
  soft_mode_a: assert property (dog_mode_config == `MODE_SOFT |-> run == soft_en_q)
    else $error("software mode ignores enable bit");
  soft_sleep_a: assert property (dog_mode_config == `MODE_SOFT && $stable(dog_mode_config) && $stable(soft_en_q) |-> $stable(run))
    else $error("sleep changed software-mode state");
  mode_off_a: assert property (dog_mode_config == `MODE_OFF |=> cif.count == '0 && !dog_reset)
    else $error("watchdog active in off mode");

  // counter clearing conditions
  clear_instr_a: assert property (dog_clear_instr |=> cif.count == '0)
    else $error("clear instruction left a count");
  sleep_clear_a: assert property (sleep_enter || sleep_exit || irq_wake |=> cif.count == '0)
    else $error("sleep transition left a count");
  fail_clear_a: assert property (osc_fail || !run |=> cif.count == '0)
    else $error("failure or disable left a count");
  startup_hold_a: assert property (osc_startup_timer [*2] |-> cif.count == '0)
    else $error("count moved during start-up timer");
  period_reset_a: assert property ($fell(sys_rst) |-> period_q == `PERIOD_RESET)
    else $error("period not at two seconds after reset");
  ratio_a: assert property (cif.timeout |-> cif.count >= watchdog_pkg::ratio_last(period_q))
    else $error("time-out before the selected ratio");
  irq_level_a: assert property (|irq_ev |=> irq_stat_q != '0)
    else $error("event not captured in status");

  // strobes, status flags and suppression of the time-out
  reset_pulse_a: assert property (dog_reset |=> !dog_reset)
    else $error("reset strobe longer than one cycle");
  wake_pulse_a: assert property (dog_wake |=> !dog_wake)
    else $error("wake strobe longer than one cycle");
  one_strobe_a: assert property (!(dog_reset && dog_wake))
    else $error("reset and wake strobes together");
  down_flag_a: assert property (sleep_enter |=> !down_n_q)
    else $error("sleep entry did not mark power-down");
  clear_flags_a: assert property (dog_clear_instr && !sleep_enter && !cif.timeout |=> to_n_q && down_n_q)
    else $error("clear instruction left a status flag low");
  count_step_a: assert property (run && tick && !cif.clear && !cif.timeout
                                 |=> cif.count == $past(cif.count) + 23'h000001)
    else $error("count did not step on a tick");
  soft_off_a: assert property (dog_mode_config == `MODE_SOFT && !soft_en_q |-> !cif.timeout)
    else $error("software mode fired while disabled");
  off_quiet_a: assert property (dog_mode_config == `MODE_OFF |-> !run && !cif.timeout)
    else $error("off mode running");
  awake_quiet_a: assert property (dog_mode_config == `MODE_AWAKE && sleep_active |-> !cif.timeout)
    else $error("awake-only mode fired in sleep");
  startup_quiet_a: assert property (osc_startup_timer |-> !cif.timeout)
    else $error("time-out during start-up timer");
  clear_quiet_a: assert property (osc_fail || irq_wake || dog_clear_instr |-> !cif.timeout)
    else $error("time-out despite a clearing event");
  period_write_a: assert property (wr_ctrl |=> period_q == $past(pwdata[`PERIOD_MSB:`PERIOD_LSB]))
    else $error("period write not taken");
  sticky_event_a: assert property (irq_stat_q[`IRQ_RST_BIT] && !wr_irq_stat |=> irq_stat_q[`IRQ_RST_BIT])
    else $error("event bit lost without a clear");

  reset_c: cover property (cif.timeout && !asleep_or_idle ##1 dog_reset);
  wake_c: cover property (sleep_active && cif.timeout ##1 dog_wake);
  w1c_c: cover property (wr_irq_stat && irq_stat_q != '0);
  idle_c: cover property (idle_active && cif.timeout ##1 dog_wake);
endmodule : watchdog_timer_core

/* watchdog_cfg.svh */
// offsets, field positions, reset values and counts for the watchdog
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

// register byte addresses on the apb bus
`define CTRL_ADDR      12'h000
`define STAT_ADDR      12'h004
`define IRQ_STAT_ADDR  12'h008
`define IRQ_MASK_ADDR  12'h00C
`define COUNT_ADDR     12'h010

// control register fields
`define SOFT_EN_BIT    0
`define PERIOD_LSB     1
`define PERIOD_MSB     5
`define PERIOD_RESET   5'h0B
`define PERIOD_MAX     5'h12

// mode configuration codes
`define MODE_OFF       2'h0
`define MODE_SOFT      2'h1
`define MODE_AWAKE     2'h2
`define MODE_ON        2'h3

// interrupt status bits
`define IRQ_RST_BIT    0
`define IRQ_WAKE_BIT   1
`define IRQ_W          2

// time base: 1 ms nominal is 2**5 ticks of the 31 kHz oscillator
`define LFO_FREQ_HZ    31000
`define BASE_TIME_US   1000
`define BASE_LOG2      5'h05
`define COUNT_W        23

`endif

/* watchdog_pkg.sv */
// types and shared arithmetic of the watchdog
`include "watchdog_cfg.svh"
package watchdog_pkg;
  typedef logic [4:0]            period_t;
  typedef logic [1:0]            mode_t;
  typedef logic [`COUNT_W-1:0]   count_t;

  // last count before time-out; reserved codes fall back to the minimum
  function automatic count_t ratio_last(input period_t ps);
    logic [4:0]        sh;
    logic [`COUNT_W:0] full;
    sh   = (ps > `PERIOD_MAX) ? `BASE_LOG2 : 5'(ps + `BASE_LOG2);
    full = {{`COUNT_W{1'b0}}, 1'b1} << sh;
    return count_t'(full - {{`COUNT_W{1'b0}}, 1'b1});
  endfunction : ratio_last
endpackage : watchdog_pkg

/* dog_count_if.sv */
// carrier between the watchdog control and its tick counter
`timescale 1ns/10ps
interface dog_count_if;
  logic                  tick;
  logic                  clear;
  logic                  run;
  watchdog_pkg::period_t period;
  logic                  timeout;
  watchdog_pkg::count_t  count;

  modport ctrl (output tick, output clear, output run, output period,
                input timeout, input count);
  modport cnt  (input tick, input clear, input run, input period,
                output timeout, output count);
endinterface : dog_count_if

/* dog_counter.sv */
// tick counter that flags a time-out at the selected prescale ratio
`timescale 1ns/10ps
`include "watchdog_cfg.svh"
module dog_counter (
  // clock and reset
  input wire logic   clk,
  input wire logic   sys_rst,
  // counter side of the carrier
  dog_count_if.cnt   bus
);
  watchdog_pkg::count_t count_q;
  watchdog_pkg::count_t last;

  // terminal count; >= so a shortened period fires at once
  assign last        = watchdog_pkg::ratio_last(bus.period);
  assign bus.timeout = bus.run & bus.tick & ~bus.clear & (count_q >= last);
  assign bus.count   = count_q;

  // clear has priority over counting
  always_ff @(posedge clk) begin
    if (sys_rst || bus.clear) begin
      count_q <= '0;
    end else if (bus.run && bus.tick) begin
      if (count_q >= last) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  tick_only_a: assert property ((!bus.tick && !bus.clear) |=> $stable(count_q))
    else $error("count moved without an oscillator tick");
  ratio_fire_a: assert property (bus.timeout |-> (count_q == last) || (count_q > last))
    else $error("time-out before the selected ratio");
  wrap_zero_a: assert property (bus.timeout |=> count_q == '0)
    else $error("counter did not restart after time-out");
  min_ratio_a: assert property ((bus.period > `PERIOD_MAX) |-> last == 23'h00001F)
    else $error("reserved period code not at the minimum");
  fire_c: cover property (bus.timeout);
endmodule : dog_counter

/* testbench.sv */
// self-checking testbench for the watchdog timer core
`timescale 1ns/10ps
`include "watchdog_cfg.svh"
module testbench;
  // bench-driven inputs, all valued at time zero
  logic        clk     = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'hF;
  logic        osc     = 1'b0;
  logic [1:0]  mode    = `MODE_ON;
  logic [2:0]  ev      = 3'h0;
  logic        slp     = 1'b0;
  logic        idl     = 1'b0;
  logic        startup = 1'b0;
  // dut outputs
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dog_reset;
  logic        dog_wake;
  logic        to_n;
  logic        down_n;
  logic        irq;
  // bookkeeping
  int          bad_count  = 0;
  int          n_compared = 0;
  int          n_rst      = 0;
  int          n_wake     = 0;
  logic [31:0] rd;
  logic        err;

  // 25 MHz system clock
  always #20 clk = ~clk;

  watchdog_timer_core dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_freq_internal_osc(osc), .dog_mode_config(mode),
    .dog_clear_instr(ev[0]), .sleep_active(slp), .idle_active(idl), .irq_wake(ev[1]),
    .osc_fail(ev[2]), .osc_startup_timer(startup), .dog_reset(dog_reset), .dog_wake(dog_wake),
    .timeout_status_flag_n(to_n), .powerdown_status_flag_n(down_n), .irq(irq)
  );

  // pulses are one cycle wide, so totals show both missing and doubled events
  always @(posedge clk) begin
    if (dog_reset === 1'b1) n_rst++;
    if (dog_wake === 1'b1) n_wake++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd & m);
  endtask : rchk

  // one oscillator period is 17 clocks, well above the synchroniser's need
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      osc <= 1'b1;
      repeat (8) @(posedge clk);
      osc <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : tick

  // bit 0 clear instruction, bit 1 interrupt wake, bit 2 oscillator failure
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // n-1 ticks must stay quiet, the n-th must give exactly the expected pulses
  task automatic expire(input int n, input int er, input int ew);
    int r0;
    int w0;
    r0 = n_rst;
    w0 = n_wake;
    tick(n - 1);
    repeat (16) @(posedge clk);
    chk("early event", r0 + w0, n_rst + n_wake);
    tick(1);
    repeat (16) @(posedge clk);
    chk("reset pulses", r0 + er, n_rst);
    chk("wake pulses", w0 + ew, n_wake);
  endtask : expire

  task automatic t_reset;
    rchk("control reset", `CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0016);
    chk("read no error", 32'h0000_0000, {31'h0, err});
    chk("ready", 32'h0000_0001, {31'h0, pready});
    pstrb <= 4'hE;
    apb(1'b1, `CTRL_ADDR, 32'h0000_003F);
    pstrb <= 4'hF;
    rchk("lane zero off", `CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0016);
    rchk("flags reset", `STAT_ADDR, 32'h0000_0006, 32'h0000_0006);
    rchk("irq status reset", `IRQ_STAT_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("count reset", `COUNT_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_period;
    apb(1'b1, `CTRL_ADDR, 32'h0000_0000);
    pulse(0);
    expire(32, 1, 0);
    chk("timeout flag", 32'h0000_0000, {31'h0, to_n});
    apb(1'b1, `CTRL_ADDR, 32'h0000_0026);
    rchk("control readback", `CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0026);
    pulse(0);
    expire(32, 1, 0);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0002);
    pulse(0);
    expire(64, 1, 0);
    $display("test period done");
  endtask : t_period

  // irq is combinational, so it is looked at away from the clock edge
  task automatic t_irq;
    rchk("reset event", `IRQ_STAT_ADDR, 32'h0000_0003, 32'h0000_0001);
    @(negedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, `IRQ_MASK_ADDR, 32'h0000_0003);
    @(negedge clk);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, `IRQ_STAT_ADDR, 32'h0000_0001);
    @(negedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rchk("event cleared", `IRQ_STAT_ADDR, 32'h0000_0003, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq

  task automatic t_count;
    apb(1'b1, `CTRL_ADDR, 32'h0000_0016);
    pulse(0);
    tick(5);
    rchk("count five", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0005);
    repeat (300) @(posedge clk);
    rchk("count no ticks", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0005);
    pulse(0);
    rchk("count clear", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0000);
    tick(3);
    pulse(2);
    rchk("count osc fail", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0000);
    startup <= 1'b1;
    tick(3);
    rchk("count startup", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0000);
    startup <= 1'b0;
    tick(2);
    rchk("count two", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0002);
    pulse(1);
    rchk("count irq wake", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0000);
    tick(2);
    mode <= `MODE_OFF;
    tick(1);
    rchk("count disabled", `COUNT_ADDR, 32'h007F_FFFF, 32'h0000_0000);
    $display("test count done");
  endtask : t_count

  // a partly run counter before sleep proves that sleep entry clears it
  task automatic t_modes;
    apb(1'b1, `CTRL_ADDR, 32'h0000_0001);
    pulse(0);
    expire(32, 0, 0);
    mode <= `MODE_SOFT;
    apb(1'b1, `CTRL_ADDR, 32'h0000_0000);
    pulse(0);
    expire(32, 0, 0);
    apb(1'b1, `CTRL_ADDR, 32'h0000_0001);
    pulse(0);
    expire(32, 1, 0);
    pulse(0);
    tick(20);
    slp <= 1'b1;
    expire(32, 0, 1);
    chk("powerdown flag", 32'h0000_0000, {31'h0, down_n});
    chk("sleep timeout flag", 32'h0000_0000, {31'h0, to_n});
    rchk("wake event", `IRQ_STAT_ADDR, 32'h0000_0002, 32'h0000_0002);
    mode <= `MODE_AWAKE;
    expire(32, 0, 0);
    mode <= `MODE_ON;
    expire(32, 0, 1);
    slp <= 1'b0;
    idl <= 1'b1;
    expire(32, 0, 1);
    idl <= 1'b0;
    $display("test modes done");
  endtask : t_modes

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // the tests need under 10000 clocks; four times that means a hang
  initial begin
    #(40 * 40000);
    bad_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end

  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_period();
    t_irq();
    t_count();
    t_modes();
    summarize();
  end
endmodule : testbench
